// ---- shared/egp_consts.vh ----
// register indices, field codes and reset values of the eight-pad port
`ifndef EGP_CONSTS_VH
`define EGP_CONSTS_VH
`define EGP_NPADS          8
`define EGP_ADDR_W         18
`define EGP_IDX_LEVEL      16'hF2DE
`define EGP_IDX_DIR        16'hF2DF
`define EGP_IDX_DRV_LO     16'hF2E0
`define EGP_IDX_DRV_HI     16'hF2E1
`define EGP_IDX_FUN_LO     16'hF2E2
`define EGP_IDX_FUN_HI     16'hF2E3
`define EGP_RST_BYTE       8'h00
`define EGP_DIR_OUT        1'b0
`define EGP_DIR_IN         1'b1
`define EGP_DRV_HIZ        2'b00
`define EGP_DRV_HI_OD      2'b01
`define EGP_DRV_LO_OD      2'b10
`define EGP_DRV_PUSH       2'b11
`define EGP_FUN_GPIO       2'b00
`define EGP_FUN_SECOND     2'b01
`define EGP_FUN_THIRD      2'b10
`define EGP_FUN_UNUSED     2'b11
`define EGP_NO_SECOND_MASK 8'h0C
`endif

// ---- core/egp_pad_cell.v ----
// combinational drive and termination decode for one pad
`default_nettype none
`include "egp_consts.vh"
module egp_pad_cell (
    input  wire       dir_in,
    input  wire [1:0] drv_sel,
    input  wire       code_bad,
    input  wire       out_val,
    output reg        pad_o,
    output reg        pad_oe,
    output reg        pull_up,
    output reg        pull_dn
);
    always @* begin
        pad_o   = 1'b0;
        pad_oe  = 1'b0;
        pull_up = 1'b0;
        pull_dn = 1'b0;
        if (dir_in == `EGP_DIR_IN) begin
            // 00 and 11 both float the input
            pull_dn = (drv_sel == `EGP_DRV_HI_OD);
            pull_up = (drv_sel == `EGP_DRV_LO_OD);
        end else if (code_bad) begin
            // unusable code: data ignored, low-side styles hold the pad low
            pad_oe = drv_sel[1];
        end else begin
            case (drv_sel)
                `EGP_DRV_HI_OD: begin
                    pad_o  = 1'b1;
                    pad_oe = out_val;
                end
                `EGP_DRV_LO_OD: begin
                    pad_oe = ~out_val;
                end
                `EGP_DRV_PUSH: begin
                    pad_o  = out_val;
                    pad_oe = 1'b1;
                end
                default: begin
                    pad_oe = 1'b0;
                end
            endcase
        end
    end
endmodule // egp_pad_cell
`default_nettype wire

// ---- core/egp_port.v ----
// eight-pad general-purpose port with drive, pull and alternate-function muxing
//
// The APB interface to the registers was decided locally.
`default_nettype none
`include "egp_consts.vh"
module egp_port (
    input  wire        core_clk,
    input  wire        sys_rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [17:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [7:0]  pad_in,
    output reg  [7:0]  pad_out,
    output reg  [7:0]  pad_oe,
    output reg  [7:0]  pad_pull_up,
    output reg  [7:0]  pad_pull_dn,
    input  wire        i2c_sda_o,
    input  wire        i2c_scl_o,
    input  wire        sync_serial_clk_o,
    input  wire        sync_serial_out,
    input  wire        uart_a_tx,
    input  wire        uart_b_tx,
    input  wire        pwm_ch_four,
    input  wire        pwm_ch_five,
    output reg         i2c_sda_i,
    output reg         i2c_scl_i,
    output reg         sync_serial_clk_i,
    output reg         sync_serial_in,
    output reg         uart_a_rx,
    output reg         uart_b_rx
);
    reg  [7:0]  level_q;
    reg  [7:0]  dir_q;
    reg  [7:0]  drv_lo_q;
    reg  [7:0]  drv_hi_q;
    reg  [7:0]  fun_lo_q;
    reg  [7:0]  fun_hi_q;
    reg  [7:0]  sync1_q;
    reg  [7:0]  sync2_q;
    reg  [7:0]  sync3_q;
    reg  [7:0]  pin_q;
    reg  [7:0]  alt_val;
    reg  [7:0]  rd_byte;
    reg  [31:0] rd_d;
    reg         hit;
    wire [15:0] idx;
    wire        acc_first;
    wire        wr_take;
    wire [7:0]  alt_on;
    wire [7:0]  code_bad;
    wire [7:0]  cell_o;
    wire [7:0]  cell_oe;
    wire [7:0]  cell_pu;
    wire [7:0]  cell_pd;
    wire [7:0]  level_rd;
    wire [7:0]  sel_second;
    wire [7:0]  sel_third;
    wire [7:0]  sync_agree;

    // pads without a secondary function: code 01 is unusable there
    localparam [7:0] NO_SECOND = `EGP_NO_SECOND_MASK;

    // register offsets are word indices; byte address is four times that
    assign idx       = paddr[17:2];
    assign acc_first = psel & penable & ~pready;
    assign wr_take   = psel & penable & pready & pwrite & ~pslverr;

    // input-mode pads read the synchronised pin, output pads the stored bit
    assign level_rd = (dir_q & pin_q) | (~dir_q & level_q);

    // per-pad function code decode shared by the peripheral input routing
    assign sel_second = fun_lo_q & ~fun_hi_q;
    assign sel_third  = fun_hi_q & ~fun_lo_q;

    always @* begin
        hit     = 1'b1;
        rd_byte = 8'h00;
        rd_d    = 32'h0000_0000;
        case (idx)
            `EGP_IDX_LEVEL: begin
                rd_byte = level_rd;
            end
            `EGP_IDX_DIR: begin
                rd_byte = dir_q;
            end
            `EGP_IDX_DRV_LO: begin
                rd_d[15:8] = drv_hi_q;
                rd_byte    = drv_lo_q;
            end
            `EGP_IDX_DRV_HI: begin
                rd_byte = drv_hi_q;
            end
            `EGP_IDX_FUN_LO: begin
                rd_d[15:8] = fun_hi_q;
                rd_byte    = fun_lo_q;
            end
            `EGP_IDX_FUN_HI: begin
                rd_byte = fun_hi_q;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        rd_d[7:0] = rd_byte;
    end

    // one wait state: data and status are registered at the same edge that raises pready
    always @(posedge core_clk) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready <= acc_first;
            if (acc_first) begin
                pslverr <= ~hit;
                prdata  <= (pwrite | ~hit) ? 32'h0000_0000 : rd_d;
            end else begin
                pslverr <= 1'b0;
                prdata  <= 32'h0000_0000;
            end
        end
    end

    // writes land only at the completing edge; lane 1 at a low index is the word's upper byte
    always @(posedge core_clk) begin
        if (sys_rst) begin
            level_q  <= `EGP_RST_BYTE;
            dir_q    <= `EGP_RST_BYTE;
            drv_lo_q <= `EGP_RST_BYTE;
            drv_hi_q <= `EGP_RST_BYTE;
            fun_lo_q <= `EGP_RST_BYTE;
            fun_hi_q <= `EGP_RST_BYTE;
        end else if (wr_take) begin
            case (idx)
                `EGP_IDX_LEVEL: begin
                    if (pstrb[0]) level_q <= pwdata[7:0];
                end
                `EGP_IDX_DIR: begin
                    if (pstrb[0]) dir_q <= pwdata[7:0];
                end
                `EGP_IDX_DRV_LO: begin
                    if (pstrb[0]) drv_lo_q <= pwdata[7:0];
                    if (pstrb[1]) drv_hi_q <= pwdata[15:8];
                end
                `EGP_IDX_DRV_HI: begin
                    if (pstrb[0]) drv_hi_q <= pwdata[7:0];
                end
                `EGP_IDX_FUN_LO: begin
                    if (pstrb[0]) fun_lo_q <= pwdata[7:0];
                    if (pstrb[1]) fun_hi_q <= pwdata[15:8];
                end
                `EGP_IDX_FUN_HI: begin
                    if (pstrb[0]) fun_hi_q <= pwdata[7:0];
                end
                default: begin
                    level_q <= level_q;
                end
            endcase
        end
    end

    // three-stage synchroniser; the filtered level moves only when stages two and three agree
    assign sync_agree = ~(sync2_q ^ sync3_q);

    always @(posedge core_clk) begin
        if (sys_rst) begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
            sync3_q <= 8'h00;
            pin_q   <= 8'h00;
        end else begin
            sync1_q <= pad_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            pin_q   <= (sync_agree & sync2_q) | (~sync_agree & pin_q);
        end
    end

    // alternate output sources per pad; inputs-only functions leave the level bit in place
    always @* begin
        alt_val = level_q;
        alt_val[0] = fun_lo_q[0] ? i2c_sda_o : level_q[0];
        alt_val[1] = fun_lo_q[1] ? i2c_scl_o : sync_serial_clk_o;
        alt_val[2] = sync_serial_out;
        alt_val[3] = pwm_ch_five;
        alt_val[4] = level_q[4];
        alt_val[5] = fun_lo_q[5] ? uart_b_tx : sync_serial_clk_o;
        alt_val[6] = fun_lo_q[6] ? level_q[6] : sync_serial_out;
        alt_val[7] = fun_lo_q[7] ? uart_a_tx : pwm_ch_four;
    end

    genvar g;
    generate
        for (g = 0; g < `EGP_NPADS; g = g + 1) begin : g_pad
            // 11 is unusable everywhere, 01 also on pads without a secondary
            assign code_bad[g] = (fun_hi_q[g] & fun_lo_q[g]) |
                                 (~fun_hi_q[g] & fun_lo_q[g] & NO_SECOND[g]);
            assign alt_on[g]   = fun_hi_q[g] | fun_lo_q[g];
            egp_pad_cell egp_pad_cell_i (
                .dir_in   (dir_q[g]),
                .drv_sel  ({drv_hi_q[g], drv_lo_q[g]}),
                .code_bad (code_bad[g]),
                .out_val  (alt_on[g] ? alt_val[g] : level_q[g]),
                .pad_o    (cell_o[g]),
                .pad_oe   (cell_oe[g]),
                .pull_up  (cell_pu[g]),
                .pull_dn  (cell_pd[g])
            );
        end
    endgenerate

    // pad outputs registered: one cycle of latency after any register write
    always @(posedge core_clk) begin
        if (sys_rst) begin
            pad_out     <= 8'h00;
            pad_oe      <= 8'h00;
            pad_pull_up <= 8'h00;
            pad_pull_dn <= 8'h00;
        end else begin
            pad_out     <= cell_o;
            pad_oe      <= cell_oe;
            pad_pull_up <= cell_pu;
            pad_pull_dn <= cell_pd;
        end
    end

    // peripheral inputs idle high when no pad routes them, so no receiver sees a false start
    always @(posedge core_clk) begin
        if (sys_rst) begin
            i2c_sda_i         <= 1'b1;
            i2c_scl_i         <= 1'b1;
            sync_serial_clk_i <= 1'b1;
            sync_serial_in    <= 1'b1;
            uart_a_rx         <= 1'b1;
            uart_b_rx         <= 1'b1;
        end else begin
            // bus lines read the pad back in either direction, as open-drain signalling needs
            if (sel_second[0]) begin
                i2c_sda_i <= pin_q[0];
            end else begin
                i2c_sda_i <= 1'b1;
            end
            if (sel_second[1]) begin
                i2c_scl_i <= pin_q[1];
            end else begin
                i2c_scl_i <= 1'b1;
            end
            if (sel_third[1]) begin
                sync_serial_clk_i <= pin_q[1];
            end else if (sel_third[5]) begin
                sync_serial_clk_i <= pin_q[5];
            end else begin
                sync_serial_clk_i <= 1'b1;
            end
            // pad 0 wins if both serial-input pads are selected
            if (sel_third[0]) begin
                sync_serial_in <= pin_q[0];
            end else if (sel_third[4]) begin
                sync_serial_in <= pin_q[4];
            end else begin
                sync_serial_in <= 1'b1;
            end
            if (sel_second[4]) begin
                uart_b_rx <= pin_q[4];
            end else begin
                uart_b_rx <= 1'b1;
            end
            if (sel_second[6]) begin
                uart_a_rx <= pin_q[6];
            end else begin
                uart_a_rx <= 1'b1;
            end
        end
    end
endmodule // egp_port
`default_nettype wire

// ---- sim/egp_port_assertions.sv ----
// assertion checker for the eight-pad port and its bind
`default_nettype none
`include "egp_consts.vh"
module egp_port_assertions (
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  pad_oe,
    input wire logic [7:0]  pad_pull_up,
    input wire logic [7:0]  pad_pull_dn
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire [15:0] idx  = paddr[17:2];
    wire        hit  = idx >= `EGP_IDX_LEVEL && idx <= `EGP_IDX_FUN_HI;
    wire        wide = idx == `EGP_IDX_DRV_LO || idx == `EGP_IDX_FUN_LO;
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready stood more than one cycle");
    chk_one_wait: assert property ($rose(penable) && psel |=> pready)
        else $error("access did not end after one wait state");
    chk_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside an access phase");
    chk_idle_zero: assert property (!pready |-> prdata == 32'h00000000)
        else $error("read data not zero while idle");
    chk_unmapped_err: assert property (pready && !hit |-> pslverr && prdata == 32'h00000000)
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (pready && hit |-> !pslverr)
        else $error("mapped access refused");
    chk_byte_upper: assert property (pready && !pwrite && hit && !wide |-> prdata[31:8] == 24'h000000)
        else $error("byte register read has upper bits set");
    chk_word_upper: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("read data above the word is set");
    chk_pull_excl: assert property ((pad_pull_up & pad_pull_dn) == 8'h00)
        else $error("pull-up and pull-down on together");
    chk_pull_undriven: assert property (((pad_pull_up | pad_pull_dn) & pad_oe) == 8'h00)
        else $error("pull resistor on a driven pad");
endmodule // egp_port_assertions
bind egp_port egp_port_assertions egp_port_assertions_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_oe(pad_oe),
    .pad_pull_up(pad_pull_up), .pad_pull_dn(pad_pull_dn)
);
`default_nettype wire

// ---- sim/egp_board.sv ----
// board model: resolves pad levels from drive, pulls and an outside source
`default_nettype none
module egp_board (
    input  wire logic       core_clk,
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe,
    input  wire logic [7:0] pull_up,
    input  wire logic [7:0] pull_dn,
    input  wire logic       ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] flt_q = 8'h55;
    // a floating pad toggles every cycle, which the port's filter never passes, so a missing pull reads as the last settled level
    always @(posedge core_clk) flt_q <= ~flt_q;
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & (ext_en ? ext_val : (pull_up | (~pull_dn & flt_q))));
endmodule // egp_board
`default_nettype wire

// ---- sim/egp_port_tb.sv ----
// self-checking testbench for the eight-pad port
`default_nettype none
`include "egp_consts.vh"
module egp_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [17:0] A_LV  = {`EGP_IDX_LEVEL, 2'b00};
    localparam [17:0] A_DR  = {`EGP_IDX_DIR, 2'b00};
    localparam [17:0] A_DL  = {`EGP_IDX_DRV_LO, 2'b00};
    localparam [17:0] A_DH  = {`EGP_IDX_DRV_HI, 2'b00};
    localparam [17:0] A_FL  = {`EGP_IDX_FUN_LO, 2'b00};
    localparam [17:0] A_FH  = {`EGP_IDX_FUN_HI, 2'b00};
    localparam [17:0] A_BAD = {16'hF2E4, 2'b00};
    logic        core_clk = 1'b0;
    logic        sys_rst  = 1'b1;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [17:0] paddr    = 18'h00000;
    logic [31:0] pwdata   = 32'h00000000;
    logic [3:0]  pstrb    = 4'h0;
    logic [7:0]  per      = 8'h00;
    logic        ext_en   = 1'b0;
    logic [7:0]  ext_val  = 8'h00;
    logic [31:0] prdata, rd_q;
    logic        pready, pslverr, er_q;
    logic [7:0]  pad_in, pad_out, pad_oe, pu, pd;
    logic [5:0]  to_per;
    int          num_errors = 0;
    int          n_tests    = 0;
    always #4 core_clk = ~core_clk;
    egp_port egp_port_i (
        .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pu),
        .pad_pull_dn(pd), .i2c_sda_o(per[0]), .i2c_scl_o(per[1]), .sync_serial_clk_o(per[2]),
        .sync_serial_out(per[3]), .uart_a_tx(per[4]), .uart_b_tx(per[5]), .pwm_ch_four(per[6]),
        .pwm_ch_five(per[7]), .i2c_sda_i(to_per[0]), .i2c_scl_i(to_per[1]),
        .sync_serial_clk_i(to_per[2]), .sync_serial_in(to_per[3]), .uart_a_rx(to_per[4]),
        .uart_b_rx(to_per[5])
    );
    egp_board egp_board_i (
        .core_clk(core_clk), .pad_out(pad_out), .pad_oe(pad_oe), .pull_up(pu), .pull_dn(pd),
        .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in)
    );
    task automatic report_and_stop;
        $display("counts: %0d mismatches in %0d compares", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d, input logic [3:0] s);
        int i;
        @(posedge core_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge core_clk);
        penable <= 1'b1;
        // pready is sampled at each rising edge; the edge that sees it high completes the access
        for (i = 0; i < 16; i++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (pready !== 1'b1) begin
            num_errors++;
            report_and_stop();
        end
        rd_q = prdata;
        er_q = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [17:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF);
    endtask
    task automatic rd(input logic [17:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000, 4'h0);
        chk(rd_q, e);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic t_reset;
        rd(A_LV, 32'h0);
        rd(A_DR, 32'h0);
        rd(A_DL, 32'h0);
        rd(A_DH, 32'h0);
        rd(A_FL, 32'h0);
        rd(A_FH, 32'h0);
        chk(pad_oe | pu | pd, 32'h0);
        rd(A_BAD, 32'h0);
        chk(er_q, 32'h1);
    endtask
    task automatic t_regs;
        wr(A_LV, 32'hFFFFFFA5);
        rd(A_LV, 32'hA5);
        apb(1'b1, A_LV, 32'h00000000, 4'h2);
        rd(A_LV, 32'hA5);
        wr(A_DL, 32'h0000A55A);
        rd(A_DL, 32'hA55A);
        rd(A_DH, 32'hA5);
        wr(A_FH, 32'h5A);
        rd(A_FL, 32'h5A00);
    endtask
    task automatic t_styles(input logic [7:0] lv, input logic [15:0] fn, input logic [31:0] tab);
        int c;
        wr(A_FL, {16'h0000, fn});
        wr(A_LV, {24'h000000, lv});
        for (c = 0; c < 4; c++) begin
            wr(A_DL, {16'h0000, {8{c[1]}}, {8{c[0]}}});
            settle(3);
            chk(pad_oe, tab[8*c +: 8]);
            chk(pad_out & tab[8*c +: 8], (fn == 16'h0000 ? lv : 8'h00) & tab[8*c +: 8]);
        end
    endtask
    task automatic t_input;
        wr(A_DR, 32'hFF);
        wr(A_DL, 32'h00FF);
        settle(6);
        chk({pu, pd, pad_oe}, 32'h00FF00);
        chk(to_per, 32'h3F);
        rd(A_LV, 32'h00);
        wr(A_DL, 32'hFF00);
        settle(6);
        chk({pu, pd}, 32'hFF00);
        rd(A_LV, 32'hFF);
        ext_en  <= 1'b1;
        ext_val <= 8'h3C;
        rd(A_LV, 32'hFF);
        wr(A_LV, 32'hC3);
        settle(6);
        rd(A_LV, 32'h3C);
        wr(A_FL, 32'h00FF);
        settle(3);
        chk(to_per, 32'h2C);
        wr(A_FL, 32'hFF00);
        settle(3);
        chk(to_per, 32'h33);
        @(posedge core_clk);
        ext_en  <= 1'b0;
    endtask
    task automatic t_alt;
        wr(A_DR, 32'h00);
        wr(A_DL, 32'hFFFF);
        wr(A_LV, 32'hFF);
        wr(A_FL, 32'hFF00);
        per <= 8'hFF;
        settle(3);
        chk(pad_out & 8'hEE, 32'hEE);
        @(posedge core_clk);
        per <= 8'h00;
        settle(3);
        chk(pad_out & 8'hEE, 32'h00);
        @(posedge core_clk);
        per <= 8'h44;
        settle(3);
        chk(pad_out, 32'hB3);
        wr(A_FL, 32'h00FF);
        per <= 8'h00;
        settle(3);
        chk(pad_out & 8'hFC, 32'h50);
        @(posedge core_clk);
        per <= 8'hFF;
        settle(3);
        chk(pad_out & 8'hFC, 32'hF0);
        @(posedge core_clk);
        per <= 8'h21;
        settle(3);
        chk(pad_out, 32'h71);
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_regs();
        t_styles(8'h0F, 16'h0000, 32'hFFF00F00);
        t_input();
        t_alt();
        t_styles(8'hFF, 16'hFFFF, 32'hFFFF0000);
        report_and_stop();
    end
endmodule // egp_port_tb
`default_nettype wire
